// ### rtl/sdsp_pkg.sv
// constants, types and pin map shared by the dual spi block
// assumes a single 40 MHz functional clock
package sdsp_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_HZ = 40_000_000;
  localparam int SCK_HZ = 2_000_000;
  localparam int BAUD_DIV = CLK_HZ / SCK_HZ;
  localparam logic [7:0] HALF_DIV_RST = 8'(BAUD_DIV / 2 - 1);
  localparam logic [5:0] BITS_RST = 6'h08;
  localparam logic [WORD_W-1:0] MATCH_RST = 32'h0000_0000;
  localparam logic [15:0] T1_CMP = 16'hFFFF;

  // ----------------------------------------------------------------
  // pin map: master 0..3, slave 4..7
  // ----------------------------------------------------------------
  localparam int PIN_M_SOUT = 0;
  localparam int PIN_M_SIN = 1;
  localparam int PIN_M_SCK = 2;
  localparam int PIN_M_CS = 3;
  localparam int PIN_S_SOUT = 4;
  localparam int PIN_S_SIN = 5;
  localparam int PIN_S_SCK = 6;
  localparam int PIN_S_CS = 7;
  localparam logic [7:0] PIN_OE = 8'h1D;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] bits;
    logic [7:0] half_div;
    logic [WORD_W-1:0] match;
  } sdsp_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic valid;
    logic match;
  } sdsp_rx_t;

  typedef enum logic [1:0] {
    T0_IDLE = 2'b00,
    T0_START = 2'b01,
    T0_RUN = 2'b10,
    T0_STOP = 2'b11
  } sdsp_t0_st_t;

endpackage

// ### rtl/sdsp_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module sdsp_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_q, rd_q;
  logic push, pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(D);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ### rtl/sdsp_top.sv
// dual spi: timer-driven master on pins 0..3 and slave on pins 4..7
// assumes pin inputs are asynchronous; settings held stable during frames
//
// Function
// - 32-bit shifters, tx/rx/match, double buffered
// - transmit shifter loads buffer, drives bits
// - receive shifter samples, stores completed word
// - only the assigned timer loads/stores/shifts
// - default cpha0, 2 MHz, 8-bit words
// - master pins 0-3, slave pins 4-7
// - master tx by timer0, falling edge, pin0
// - master rx by timer0, rising edge, pin1
// - no start/stop bits; tx loads on enable
// - flag set on load; trigger starts timer0
// - timer0 baud/bit, sck pin2, start/stop bits
// - compare: edges 2n-1, half divider minus one
// - timer0 disables at compare; shifting until then
// - timer1 follows timer0 enable and disable
// - timer1 drives active-low chip select pin3
// - slave tx by timer2, falling edge, pin4
// - slave rx by timer2, rising edge, pin5
// - slave sck and cs are inputs only
// - slave shifts only while cs asserted
// - timer2 counts pin6 edges, starts on cs
// - timer2 never disabled or reset
`timescale 1ns/1ps
module sdsp_top
  import sdsp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pins
  input wire logic [7:0] io_pin_in,
  output logic [7:0] io_pin_out,
  output logic [7:0] io_pin_oe,
  // settings
  input wire sdsp_cfg_t cfg,
  // master transmit words
  input wire logic mst_tx_valid,
  output logic mst_tx_ready,
  input wire logic [WORD_W-1:0] mst_tx_data,
  // slave transmit buffer
  input wire logic slv_tx_valid,
  output logic slv_tx_ready,
  input wire logic [WORD_W-1:0] slv_tx_data,
  // received words
  output sdsp_rx_t mst_rx,
  output sdsp_rx_t slv_rx,
  // status
  output logic mst_busy,
  output logic slv_active
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // index 0: master sin, 1: slave sin, 2: slave sck, 3: slave cs
  logic [3:0] raw, s1_q, s2_q, s3_q, flt_q;
  assign raw = {io_pin_in[PIN_S_CS], io_pin_in[PIN_S_SCK], io_pin_in[PIN_S_SIN], io_pin_in[PIN_M_SIN]};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // idle levels: cs high, rest low, so release shows no false cs fall
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 4'h8;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // cs filter resets high so no frame is seen out of reset
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flt
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          flt_q[gi] <= (gi == 3);
        end else if (s2_q[gi] == s3_q[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic m_sin, s_sin, s_sck, s_cs;
  assign m_sin = flt_q[0];
  assign s_sin = flt_q[1];
  assign s_sck = flt_q[2];
  assign s_cs = flt_q[3];

  // ----------------------------------------------------------------
  // master transmit fifo and buffer
  // ----------------------------------------------------------------
  logic f_valid;
  logic [WORD_W-1:0] f_data;
  logic m_flag_q;
  logic [WORD_W-1:0] m_buf_q;
  logic m_load;

  sdsp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(mst_tx_valid),
    .in_ready(mst_tx_ready),
    .in_data(mst_tx_data),
    .out_valid(f_valid),
    .out_ready(m_flag_q),
    .out_data(f_data)
  );

  // flag high means buffer empty; load and write never coincide
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      m_flag_q <= 1'b1;
      m_buf_q <= '0;
    end else if (m_load) begin
      m_flag_q <= 1'b1;
    end else if (f_valid && m_flag_q) begin
      m_buf_q <= f_data;
      m_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // timer 0: baud/bit, sck generation
  // ----------------------------------------------------------------
  sdsp_t0_st_t t0_st_q;
  logic [7:0] baud_q, edge_q;
  logic sck_q, tick, t0_cmp, m_rise, m_fall;

  assign tick = (t0_st_q != T0_IDLE) && (baud_q == 8'h00);
  assign m_load = (t0_st_q == T0_IDLE) && !m_flag_q;
  assign m_rise = (t0_st_q == T0_RUN) && tick && !sck_q;
  assign m_fall = (t0_st_q == T0_RUN) && tick && sck_q;
  assign t0_cmp = m_fall && (edge_q == 8'h00);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      t0_st_q <= T0_IDLE;
      baud_q <= 8'h00;
      edge_q <= 8'h00;
    end else begin
      unique case (t0_st_q)
        T0_IDLE: begin
          if (m_load) begin
            t0_st_q <= T0_START;
            baud_q <= cfg.half_div;
            edge_q <= 8'({cfg.bits, 1'b0} - 7'h01);
          end
        end
        T0_START: begin
          if (tick) begin
            t0_st_q <= T0_RUN;
          end
        end
        T0_RUN: begin
          if (t0_cmp) begin
            t0_st_q <= T0_STOP;
          end
          if (tick) begin
            edge_q <= edge_q - 8'h01;
          end
        end
        T0_STOP: begin
          if (tick) begin
            t0_st_q <= T0_IDLE;
          end
        end
      endcase
      if (t0_st_q != T0_IDLE) begin
        baud_q <= tick ? cfg.half_div : baud_q - 8'h01;
      end
    end
  end

  // sck toggles only on run ticks and is forced low outside a frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
    end else if (m_load || t0_st_q == T0_IDLE) begin
      sck_q <= 1'b0;
    end else if (t0_st_q == T0_RUN && tick) begin
      sck_q <= ~sck_q;
    end
  end

  // ----------------------------------------------------------------
  // timer 1: chip select follows timer 0
  // ----------------------------------------------------------------
  logic t1_en_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      t1_en_q <= 1'b0;
    end else if (m_load) begin
      t1_en_q <= 1'b1;
    end else if (t0_st_q == T0_STOP && tick) begin
      t1_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // master shifters
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] m_tx_sh_q, m_rx_sh_q;
  logic [4:0] msb_idx;
  assign msb_idx = 5'(cfg.bits - 6'h01);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      m_tx_sh_q <= '0;
      m_rx_sh_q <= '0;
    end else begin
      if (m_load) begin
        m_tx_sh_q <= m_buf_q;
        m_rx_sh_q <= '0;
      end else if (m_fall && !t0_cmp) begin
        m_tx_sh_q <= {m_tx_sh_q[WORD_W-2:0], 1'b0};
      end
      if (m_rise) begin
        m_rx_sh_q <= {m_rx_sh_q[WORD_W-2:0], m_sin};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mst_rx <= '0;
    end else begin
      mst_rx.valid <= t0_cmp;
      mst_rx.match <= t0_cmp && (m_rx_sh_q == cfg.match);
      if (t0_cmp) begin
        mst_rx.data <= m_rx_sh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer 2: slave, counts sck edges while cs low
  // ----------------------------------------------------------------
  logic sck_prev_q, cs_prev_q, t2_en_q;
  logic [15:0] t2_cnt_q;
  logic trig_rise, s_edge, s_rise, s_fall, s_cmp, s_load;

  assign trig_rise = cs_prev_q && !s_cs;
  assign s_edge = t2_en_q && !s_cs && (s_sck != sck_prev_q);
  assign s_rise = s_edge && s_sck;
  assign s_fall = s_edge && !s_sck;
  assign s_cmp = s_edge && (t2_cnt_q == 16'h0000);
  assign s_load = (trig_rise && !t2_en_q) || s_cmp;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      t2_en_q <= 1'b0;
      t2_cnt_q <= 16'h0000;
    end else begin
      sck_prev_q <= s_sck;
      cs_prev_q <= s_cs;
      if (trig_rise && !t2_en_q) begin
        t2_en_q <= 1'b1;
        t2_cnt_q <= 16'({cfg.bits, 1'b0} - 7'h01);
      end else if (s_cmp) begin
        t2_cnt_q <= 16'({cfg.bits, 1'b0} - 7'h01);
      end else if (s_edge) begin
        t2_cnt_q <= t2_cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // slave buffer and shifters
  // ----------------------------------------------------------------
  logic s_flag_q;
  logic [WORD_W-1:0] s_buf_q, s_tx_sh_q, s_rx_sh_q;

  // writes are held off in a load cycle so no word is lost
  assign slv_tx_ready = s_flag_q && !s_load;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_flag_q <= 1'b1;
      s_buf_q <= '0;
    end else if (s_load) begin
      s_flag_q <= 1'b1;
    end else if (slv_tx_valid && s_flag_q) begin
      s_buf_q <= slv_tx_data;
      s_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_tx_sh_q <= '0;
      s_rx_sh_q <= '0;
    end else begin
      if (s_load) begin
        s_tx_sh_q <= s_buf_q;
      end else if (s_fall) begin
        s_tx_sh_q <= {s_tx_sh_q[WORD_W-2:0], 1'b0};
      end
      if (s_rise) begin
        s_rx_sh_q <= {s_rx_sh_q[WORD_W-2:0], s_sin};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slv_rx <= '0;
    end else begin
      slv_rx.valid <= s_cmp;
      slv_rx.match <= s_cmp && (s_rx_sh_q == cfg.match);
      if (s_cmp) begin
        slv_rx.data <= s_rx_sh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------
  always_comb begin
    io_pin_out = 8'h00;
    io_pin_out[PIN_M_SOUT] = m_tx_sh_q[msb_idx];
    io_pin_out[PIN_M_SCK] = sck_q;
    io_pin_out[PIN_M_CS] = ~t1_en_q;
    io_pin_out[PIN_S_SOUT] = s_tx_sh_q[msb_idx];
  end
  assign io_pin_oe = PIN_OE;
  assign mst_busy = t0_st_q != T0_IDLE;
  assign slv_active = t2_en_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sck_idle_a: assert property (t0_st_q == T0_IDLE |-> !io_pin_out[PIN_M_SCK])
    else $error("sck not low while timer0 idle");
  cs_frame_a: assert property (t0_st_q != T0_IDLE |-> !io_pin_out[PIN_M_CS])
    else $error("chip select not low during frame");
  t1_follow_a: assert property (t1_en_q == (t0_st_q != T0_IDLE))
    else $error("timer1 not following timer0");
  sck_tick_a: assert property ($changed(sck_q) && $past(t0_st_q) != T0_IDLE |-> $past(tick))
    else $error("sck changed off a baud tick");
  trig_start_a: assert property (t0_st_q == T0_IDLE && !m_flag_q |=> t0_st_q == T0_START && m_flag_q)
    else $error("timer0 did not start on trigger");
  start_low_a: assert property (t0_st_q == T0_START |-> !sck_q)
    else $error("start half period not low");
  cmp_stop_a: assert property (mst_rx.valid |-> t0_st_q == T0_STOP ##1 t0_st_q != T0_RUN)
    else $error("master word stored outside compare");
  slv_cs_a: assert property (slv_rx.valid |-> $past(!s_cs))
    else $error("slave stored word with cs high");
  t2_stay_a: assert property (t2_en_q |=> t2_en_q)
    else $error("timer2 disabled");
  t2_start_a: assert property ($rose(t2_en_q) |-> $past(cs_prev_q && !s_cs))
    else $error("timer2 enabled without cs falling");
  pin_dir_a: assert property (!io_pin_oe[PIN_S_SCK] && !io_pin_oe[PIN_S_CS])
    else $error("slave sck or cs driven");

  mframe_c: cover property (mst_rx.valid);
  sframe_c: cover property (slv_rx.valid);
  fifo_full_c: cover property (!mst_tx_ready);
  match_c: cover property (mst_rx.match || slv_rx.match);
  dflt_cfg_c: cover property (mst_rx.valid && cfg.bits == BITS_RST && cfg.half_div == HALF_DIV_RST);

endmodule

// ### verif/sdsp_peer.sv
// behavioural spi peers: a slave on the master pins, a master task for the slave pins
// assumes plain wires with no pull resistors and clock polarity zero
`timescale 1ns/1ps
module sdsp_peer (
  // clock
  input wire logic ref_clk,
  // master-side pins
  input wire logic m_sout,
  input wire logic m_sck,
  input wire logic m_cs_n,
  output logic m_sin,
  // slave-side pins
  input wire logic s_sout,
  output logic s_sin,
  output logic s_sck,
  output logic s_cs_n,
  // reply word, frame length, last word heard
  input wire logic [31:0] rep,
  input wire logic [5:0] bits,
  output logic [31:0] got
);
  int k = 0;
  initial begin
    m_sin = 1'h0;
    s_sin = 1'h0;
    s_sck = 1'h0;
    s_cs_n = 1'h1;
    got = 32'h0;
  end

  // ----------------------------------------------------------------
  // slave facing the master pins
  // ----------------------------------------------------------------
  always @(negedge m_cs_n) begin
    k = int'(bits) - 1;
    got = 32'h0;
    m_sin = rep[k];
  end
  always @(posedge m_sck) got = {got[30:0], m_sout};
  always @(negedge m_sck) if (m_cs_n == 1'h0 && k > 0) begin
    k = k - 1;
    m_sin = rep[k];
  end
  // released line has no pull, so it shows the inverse of the last bit
  always @(posedge m_cs_n) m_sin = ~m_sin;

  // ----------------------------------------------------------------
  // master facing the slave pins
  // ----------------------------------------------------------------
  // each level lasts 6 clocks: the slave filters its pins for about 4
  task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] r);
    r = 32'h0;
    @(posedge ref_clk);
    s_cs_n <= 1'h0;
    s_sin <= d[n-1];
    repeat (8) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      s_sck <= 1'h1;
      r = {r[30:0], s_sout};
      repeat (6) @(posedge ref_clk);
      s_sck <= 1'h0;
      if (i > 0) s_sin <= d[i-1];
      repeat (6) @(posedge ref_clk);
    end
    s_cs_n <= 1'h1;
    s_sin <= ~d[0];
  endtask
endmodule

// ### verif/tb_shifter_timer_spi_master_slave.sv
// self-checking bench for the dual spi block with random words
// assumes sdsp_pkg and the design files compile first
`timescale 1ns/1ps
module tb_shifter_timer_spi_master_slave;
  import sdsp_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] pin_in, pin_out, pin_oe;
  sdsp_cfg_t cfg = {6'h08, 8'h09, 32'h0};
  logic mst_tx_valid = 1'h0, slv_tx_valid = 1'h0, mst_tx_ready, slv_tx_ready, mst_busy, slv_active;
  logic [31:0] mst_tx_data = 32'h0, slv_tx_data = 32'h0, rep = 32'h0, got, seed = 32'h76AB01E0;
  sdsp_rx_t mst_rx, slv_rx;
  logic m_sin, s_sin, s_sck, s_cs_n, sck_p = 1'h0, full_seen = 1'h0;
  logic [31:0] mq[$], gq[$], sq[$];
  logic hq[$];
  int eq[$];
  int err_count = 0, tests_run = 0, hi = 0, edges = 0;

  always #12.5 ref_clk = ~ref_clk;
  assign pin_in = {s_cs_n, s_sck, s_sin, 3'h0, m_sin, 1'h0};

  sdsp_top dut (.ref_clk(ref_clk), .nrst(nrst), .io_pin_in(pin_in), .io_pin_out(pin_out), .io_pin_oe(pin_oe),
    .cfg(cfg), .mst_tx_valid(mst_tx_valid), .mst_tx_ready(mst_tx_ready), .mst_tx_data(mst_tx_data),
    .slv_tx_valid(slv_tx_valid), .slv_tx_ready(slv_tx_ready), .slv_tx_data(slv_tx_data),
    .mst_rx(mst_rx), .slv_rx(slv_rx), .mst_busy(mst_busy), .slv_active(slv_active));
  sdsp_peer peer (.ref_clk(ref_clk), .m_sout(pin_out[0]), .m_sck(pin_out[2]), .m_cs_n(pin_out[3]), .m_sin(m_sin),
    .s_sout(pin_out[4]), .s_sin(s_sin), .s_sck(s_sck), .s_cs_n(s_cs_n), .rep(rep), .bits(cfg.bits), .got(got));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] mk(input int n);
    return n >= 32 ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
  endfunction
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] a, input logic [31:0] b, input string s);
    tests_run++;
    if (a !== b) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, s, a, b);
    end
  endtask
  task automatic hs(input logic slv, input logic [31:0] w);
    int c;
    c = 0;
    if (slv) begin
      slv_tx_valid <= 1'h1;
      slv_tx_data <= w;
    end else begin
      mst_tx_valid <= 1'h1;
      mst_tx_data <= w;
    end
    do begin
      @(negedge ref_clk);
      c++;
    end while ((slv ? slv_tx_ready : mst_tx_ready) !== 1'h1 && c < 400);
    if (c >= 400) begin
      ck(32'h0, 32'h1, "ready timeout");
      end_sim();
    end
    @(posedge ref_clk);
  endtask
  task automatic wait_q(ref logic [31:0] q[$], input int want, input int lim);
    for (int c = 0; c < lim && q.size() < want; c++) @(posedge ref_clk);
    if (q.size() < want) begin
      ck(32'h0, 32'h1, "word timeout");
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // monitor of the master pins and received words
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (mst_rx.valid === 1'h1) begin
      mq.push_back(mst_rx.data);
      gq.push_back(got);
      hq.push_back(mst_rx.match);
      eq.push_back(edges);
      edges = 0;
    end
    if (slv_rx.valid === 1'h1) begin
      sq.push_back(slv_rx.data);
      hq.push_back(slv_rx.match);
    end
    if (mst_tx_ready === 1'h0) full_seen = 1'h1;
    if (pin_out[2] === 1'h1 && sck_p === 1'h0) edges++;
    if (pin_out[2] === 1'h0 && sck_p === 1'h1) ck(hi, {24'h0, cfg.half_div} + 32'h1, "sck half period");
    hi = pin_out[2] === 1'h1 ? hi + 1 : 0;
    if (mst_busy !== 1'h1) ck(32'(pin_out[2]), 32'h0, "sck not idle low");
    if (pin_out[2] === 1'h1) ck(32'(pin_out[3]), 32'h0, "cs high inside frame");
    sck_p = pin_out[2];
  end

  // one burst of k master frames sharing one reply word
  task automatic burst(input int n, input int k, input logic [7:0] hd, input logic [31:0] r, input logic [31:0] mt);
    logic [31:0] d[$];
    logic [31:0] m;
    m = mk(n);
    @(posedge ref_clk);
    cfg <= {6'(n), hd, mt};
    rep <= r;
    for (int j = 0; j < k; j++) begin
      d.push_back(rnd());
      hs(1'h0, d[j]);
    end
    mst_tx_valid <= 1'h0;
    wait_q(mq, k, 1200 * k);
    for (int j = 0; j < k; j++) begin
      ck(gq.pop_front(), d[j] & m, "master sent word");
      ck(mq.pop_front() & m, r & m, "master received word");
      ck(eq.pop_front(), n, "sck edge count");
      ck(hq.pop_front(), (r & m) == mt, "match flag");
    end
    repeat (30) @(posedge ref_clk);
    ck({pin_out[3], mst_busy}, 32'h2, "cs released after frame");
    $display("test master burst n=%0d k=%0d done", n, k);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  int nt[6] = '{8, 1, 32, 32, 0, 0};
  logic [31:0] r, sh, bv, d, rr;
  int n;
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk);
    ck(pin_out, 32'h08, "reset pins");
    ck(pin_oe, 32'h1D, "pin directions");
    ck({mst_tx_ready, slv_tx_ready, mst_busy, slv_active}, 32'hC, "reset status");
    $display("test reset done");
    burst(8, 1, 8'h09, rnd(), 32'h0);
    for (int t = 1; t < 6; t++) begin
      r = rnd();
      n = nt[t] != 0 ? nt[t] : 1 + int'(rnd() % 32);
      burst(n, 1 + t % 3, 8'(4 + rnd() % 6), r, t == 2 ? r : ~r);
    end
    burst(8, 36, 8'h09, rnd(), 32'h0);
    ck(full_seen, 32'h1, "fifo refused when full");
    @(posedge ref_clk);
    cfg.bits <= 6'h10;
    sh = rnd();
    bv = sh;
    hs(1'h1, sh);
    slv_tx_valid <= 1'h0;
    for (int j = 0; j < 5; j++) begin
      if (j == 2 || j == 4) begin
        bv = rnd();
        hs(1'h1, bv);
        slv_tx_valid <= 1'h0;
      end
      d = rnd();
      // first frame starts from a clear shifter, so only it can match
      cfg.match <= j == 0 ? {16'h0, d[15:0]} : ~d;
      peer.xfer(d, 16, rr);
      ck(rr, sh & 32'hFFFF, "slave sent word");
      wait_q(sq, 1, 60);
      ck(sq.pop_front() & 32'hFFFF, d & 32'hFFFF, "slave received word");
      ck(hq.pop_front(), j == 0, "slave match flag");
      sh = bv;
      repeat (10) @(posedge ref_clk);
    end
    ck({slv_active, pin_oe}, 32'h11D, "slave stays active");
    $display("test slave frames done");
    end_sim();
  end
endmodule
